//--- dv/rx_side_model.sv
// receive side model: fifo occupancy, character and read pulses, bit tick.
// assumes bench pulses push/pop/flush one cycle each, same clock as the block.
`timescale 1ns/10ps

module rx_side_model
    import irq_prio_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic push,
    input  wire logic pop,
    input  wire logic flush,
    output rx_status_t rx_status,
    output logic       bit_tick
);
    logic [4:0] level;
    logic       tick_div;

    ////////////////////////////////////////////////////////////////////////////////
    // bit period every second clock, free running
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_div <= 1'b0;
        end else begin
            tick_div <= ~tick_div;
        end
    end
    assign bit_tick = tick_div;

    // fifo level; full means buffer holds a character
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            level <= 5'h00;
        end else if (flush) begin
            level <= 5'h00;
        end else if (push && level < 5'h10) begin
            level <= level + 5'h01;
        end else if (pop && level != 5'h00) begin
            level <= level - 5'h01;
        end
    end
    assign rx_status = '{level: level, full: (level != 5'h00), char_in: push, buf_read: pop, fifo_reset: flush};
endmodule

//--- dv/test_uart_interrupt_prioritizer.sv
// self-checking bench of the interrupt prioritizer, random seed fixed.
// assumes divisor access bit already clear, so enable register is reachable.
`timescale 1ns/10ps

module test_uart_interrupt_prioritizer;
    import irq_prio_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, fifo_mode = 1'b0, dma_mode = 1'b0, irq;
    logic [31:0] addr = '0, wdata = '0, rdata, v, lf = 32'hEB4A;
    logic [1:0] wls = 2'h0, trig = 2'h3;
    logic bit_tick, thw = 1'b0, the = 1'b0, msr_rd = 1'b0, cts_n = 1'b1, push = 1'b0, pop = 1'b0, flush = 1'b0;
    logic [4:0] tx_level = 5'h10;
    line_status_t lns = '0;
    rx_status_t rxs;
    int bad_count = 0, checks = 0, cyc = 0, n;

    always #20 clk = ~clk;

    rx_side_model i_rx_side_model (.clk(clk), .nrst(nrst), .push(push), .pop(pop), .flush(flush),
        .rx_status(rxs), .bit_tick(bit_tick));
    uart_interrupt_prioritizer i_uart_interrupt_prioritizer (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fifo_mode(fifo_mode), .dma_mode(dma_mode),
        .word_len_sel(wls), .rx_trigger_sel(trig), .bit_tick(bit_tick), .rx_status(rxs),
        .line_status(lns), .tx_level(tx_level), .tx_holding_empty(the), .tx_holding_write(thw),
        .modem_status_read(msr_rd), .cts_n(cts_n), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] exp_id(input logic f, input logic [2:0] c, input logic p);
        return {24'h0, f, f, 2'b00, c, ~p};
    endfunction
    function automatic int thr(input int s);
        return (s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 8 : 15;
    endfunction
    task automatic stop_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        checks++;
        if (seen !== ex) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic id_is(input logic [31:0] ex);
        repeat (3) @(posedge clk);
        rd_reg(IDENT_OFFSET, v);
        chk("ident", v, ex);
    endtask
    // one-cycle strobe: 0 line error, 1 lsr read, 2 msr read, 3 holding write, 4 push, 5 pop, 6 flush
    task automatic strobe(input int k);
        @(posedge clk);
        case (k)
            0: lns.line_error <= 1'b1;
            1: lns.lsr_read <= 1'b1;
            2: msr_rd <= 1'b1;
            3: thw <= 1'b1;
            4: push <= 1'b1;
            5: pop <= 1'b1;
            default: flush <= 1'b1;
        endcase
        @(posedge clk);
        {lns.line_error, lns.lsr_read, msr_rd, thw, push, pop, flush} <= '0;
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(IDENT_OFFSET, v);
        chk("ident", v, 32'h01);
        rd_reg(ENABLE_OFFSET, v);
        chk("enable", v, 32'h00);
        chk("irq", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            wr_reg(ENABLE_OFFSET, {lf[31:8], 3'b111, lf[4:0]}); // reserved bits 7:5 written as ones
            rd_reg(ENABLE_OFFSET, v);
            chk("enable", v, {27'h0, lf[4:0]});
        end
        // line status gated, then ranked over modem, cleared by status reads
        wr_reg(ENABLE_OFFSET, 32'h0B);
        strobe(0);
        id_is(exp_id(0, 3'h0, 0));
        wr_reg(ENABLE_OFFSET, 32'h0C);
        cts_n <= 1'b0;
        id_is(exp_id(0, CODE_LINE, 1));
        chk("irq", {31'h0, irq}, 32'h1);
        strobe(1);
        id_is(exp_id(0, CODE_MODEM, 1));
        strobe(2);
        id_is(exp_id(0, 3'h0, 0));
        chk("irq", {31'h0, irq}, 32'h0);
        // non-fifo receive ready and transmit request
        wr_reg(ENABLE_OFFSET, 32'h03);
        strobe(4);
        id_is(exp_id(0, CODE_RX_RDY, 1));
        the <= 1'b1;
        strobe(5);
        id_is(exp_id(0, CODE_TX_REQ, 1));
        strobe(3);
        id_is(exp_id(0, 3'h0, 0));
        the <= 1'b0;
        // fifo transmit half level
        fifo_mode <= 1'b1;
        tx_level <= 5'h08;
        id_is(exp_id(1, CODE_TX_REQ, 1));
        tx_level <= 5'h09;
        id_is(exp_id(1, 3'h0, 0));
        // trigger thresholds
        wr_reg(ENABLE_OFFSET, 32'h01);
        for (int s = 0; s < 4; s++) begin
            trig <= s[1:0];
            repeat (thr(s) - 1) strobe(4);
            id_is(exp_id(1, 3'h0, 0));
            strobe(4);
            id_is(exp_id(1, CODE_RX_RDY, 1));
            strobe(6);
            id_is(exp_id(1, 3'h0, 0));
        end
        // receive timeout, random word length
        trig <= 2'h3;
        lf = lfsr(lf);
        wls <= lf[1:0];
        n = 4 * (5 + lf[1:0]) + 12;
        wr_reg(ENABLE_OFFSET, 32'h00);
        strobe(4);
        strobe(4);
        repeat (2 * n + 10) @(posedge clk);
        id_is(exp_id(1, 3'h0, 0));
        wr_reg(ENABLE_OFFSET, 32'h10);
        id_is(exp_id(1, CODE_TIMEOUT, 1));
        strobe(5);
        id_is(exp_id(1, 3'h0, 0));
        repeat (2 * (n - 3) - 10) @(posedge clk);
        id_is(exp_id(1, 3'h0, 0));
        repeat (10) @(posedge clk);
        id_is(exp_id(1, CODE_TIMEOUT, 1));
        strobe(6);
        id_is(exp_id(1, 3'h0, 0));
        // event status, mask and irq
        fifo_mode <= 1'b0;
        wr_reg(EVT_STAT_OFFSET, 32'h1F);
        wr_reg(ENABLE_OFFSET, 32'h04);
        strobe(0);
        strobe(1);
        id_is(exp_id(0, 3'h0, 0));
        rd_reg(EVT_STAT_OFFSET, v);
        chk("event status", v, 32'h04);
        chk("irq", {31'h0, irq}, 32'h0);
        wr_reg(EVT_MASK_OFFSET, 32'h04);
        @(negedge clk);
        chk("irq", {31'h0, irq}, 32'h1);
        wr_reg(EVT_STAT_OFFSET, 32'h04);
        @(negedge clk);
        chk("irq", {31'h0, irq}, 32'h0);
        // modem gated off, then dma line status follows the fifo error level
        cts_n <= 1'b1;
        id_is(exp_id(0, 3'h0, 0));
        strobe(2);
        dma_mode <= 1'b1;
        lns.fifo_error <= 1'b1;
        id_is(exp_id(0, CODE_LINE, 1));
        lns.fifo_error <= 1'b0;
        id_is(exp_id(0, 3'h0, 0));
        dma_mode <= 1'b0;
        wr_reg(32'h1003_0030, 32'hFF);
        rd_reg(32'h1003_0030, v);
        chk("unmapped", v, 32'h0);
        stop_test();
    end
endmodule

//--- logic/irq_prio_pkg.sv
// package: register map, field positions, reset values and codes of the
// interrupt enable / identification logic of a serial port.
// assumes byte addressing on a 32-bit register port, 8-bit registers in the low lanes.
package irq_prio_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses)
    localparam logic [31:0] ENABLE_OFFSET   = 32'h1003_0004;
    localparam logic [31:0] IDENT_OFFSET    = 32'h1003_0008;
    localparam logic [31:0] EVT_STAT_OFFSET = 32'h1003_0024;
    localparam logic [31:0] EVT_MASK_OFFSET = 32'h1003_0028;

    // reset values
    localparam logic [7:0] ENABLE_RESET   = 8'h00;
    localparam logic [7:0] IDENT_RESET    = 8'h01;
    localparam logic [4:0] EVT_STAT_RESET = 5'h00;
    localparam logic [4:0] EVT_MASK_RESET = 5'h00;

    // enable / event bit positions (same layout in all three registers)
    localparam int RX_READY_BIT = 0;
    localparam int TX_REQ_BIT   = 1;
    localparam int LINE_BIT     = 2;
    localparam int MODEM_BIT    = 3;
    localparam int TIMEOUT_BIT  = 4;
    localparam int NUM_SOURCES  = 5;

    // identification register fields
    localparam int IDENT_PEND_BIT = 0;
    localparam int IDENT_CODE_LO  = 1;
    localparam int IDENT_CODE_HI  = 3;
    localparam int IDENT_MODE_LO  = 6;

    // source codes for the identification field
    localparam logic [2:0] CODE_MODEM   = 3'h0;
    localparam logic [2:0] CODE_TX_REQ  = 3'h1;
    localparam logic [2:0] CODE_RX_RDY  = 3'h2;
    localparam logic [2:0] CODE_LINE    = 3'h3;
    localparam logic [2:0] CODE_TIMEOUT = 3'h6;

    // receive trigger thresholds per selector value
    localparam logic [4:0] TRIG_SEL0 = 5'h01;
    localparam logic [4:0] TRIG_SEL1 = 5'h04;
    localparam logic [4:0] TRIG_SEL2 = 5'h08;
    localparam logic [4:0] TRIG_SEL3 = 5'h0F;

    // timeout length in bit periods: mul * word length + add
    localparam logic [5:0] TIMEOUT_MUL   = 6'h04;
    localparam logic [5:0] TIMEOUT_ADD   = 6'h0C;
    localparam logic [5:0] WORD_LEN_BASE = 6'h05;

    // transmit fifo half level (16 entries)
    localparam logic [4:0] TX_HALF_LEVEL = 5'h08;

    // status from the receive side, same clock
    typedef struct packed {
        logic [4:0] level;       // entries in receive fifo
        logic       full;        // non-fifo buffer holds a character
        logic       char_in;     // pulse: new character stored
        logic       buf_read;    // pulse: receive buffer read
        logic       fifo_reset;  // pulse: receive fifo reset command
    } rx_status_t;

    // status from the line status logic, same clock
    typedef struct packed {
        logic line_error;  // pulse: overrun, parity, framing or break
        logic fifo_error;  // level: error character held in fifo
        logic lsr_read;    // pulse: line status register read
    } line_status_t;

endpackage

//--- logic/uart_interrupt_prioritizer.sv
// interrupt enable, ranking and identification of a serial port.
// assumes fifo, line status and modem logic on the same clock give status pulses;
// the clear-to-send pin is asynchronous and is synchronised here.
//
// What this block does
// (RL1) reserved enable bits 7:5 and ident bits 5:4 read zero, writes dropped
// (RL2) five enable bits; a source shows pending only while enabled
// (RL3) enable bit 4 gates the receive timeout interrupt
// (RL4) timeout when fifo holds data and 4*word length+12 bit times pass idle
// (RL5) enable bit 3 gates the modem status interrupt
// (RL6) enable bit 2 gates the receive line status interrupt
// (RL7) enable bit 1 gates the transmit data request interrupt
// (RL8) enable bit 0 gates the receive data ready interrupt
// (RL9) identification register resets to 0x01, nothing pending
// (RL10) source codes: 0 modem, 1 tx, 2 rx ready, 3 line, 6 timeout
// (RL11) ident bit 0 low while an enabled source pends, else high
// (RL12) line status highest; set by errors, cleared by status read or, in dma mode, errors gone
// (RL13) rx ready second; fifo trigger level, or buffer full without fifo
// (RL14) timeout second, fifo only; cleared by fifo reset or buffer read
// (RL15) tx request third; fifo half empty, or holding empty until written
// (RL16) modem lowest; set by clear-to-send change, cleared by modem status read
// (RL17) software clears divisor access bit before touching the enable register
// (RL18) trigger selector 0..3 gives 1, 4, 8 or 15 entries
// (RL19) interrupt output high whenever an enabled source pends
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps

module uart_interrupt_prioritizer
    import irq_prio_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [31:0]  addr,
    input  wire logic [31:0]  wdata,
    input  wire logic         wr,
    input  wire logic         rd,
    output logic      [31:0]  rdata,
    input  wire logic         fifo_mode,
    input  wire logic         dma_mode,
    input  wire logic [1:0]   word_len_sel,
    input  wire logic [1:0]   rx_trigger_sel,
    input  wire logic         bit_tick,
    input  wire rx_status_t   rx_status,
    input  wire line_status_t line_status,
    input  wire logic [4:0]   tx_level,
    input  wire logic         tx_holding_empty,
    input  wire logic         tx_holding_write,
    input  wire logic         modem_status_read,
    input  wire logic         cts_n,
    output logic              irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [4:0] interrupt_enable;
    logic [7:0] interrupt_identification;
    logic [7:0] next_ident;
    logic [4:0] evt_status;
    logic [4:0] evt_mask;
    logic [4:0] pend;
    logic [4:0] pend_prev;
    logic [4:0] raw;
    logic       line_flag;
    logic       tx_flag;
    logic       tx_empty_prev;
    logic       modem_flag;
    logic       timeout_flag;
    logic [5:0] idle_bits;
    logic [5:0] timeout_len;
    logic [4:0] trigger_level;
    logic       timeout_hit;
    logic       cts_meta;
    logic       cts_sync;
    logic       cts_prev;
    logic       en_wr;
    logic       stat_wr;
    logic       mask_wr;

    assign en_wr   = wr && (addr == ENABLE_OFFSET);
    assign stat_wr = wr && (addr == EVT_STAT_OFFSET);
    assign mask_wr = wr && (addr == EVT_MASK_OFFSET);

    ////////////////////////////////////////////////////////////////////////////////
    // enable register; only the five low bits are stored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            interrupt_enable <= ENABLE_RESET[4:0];
        end else if (en_wr) begin
            interrupt_enable <= wdata[4:0];  // see RL1, see RL2
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clear-to-send synchroniser and change detector
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cts_meta <= 1'b1;
            cts_sync <= 1'b1;
            cts_prev <= 1'b1;
        end else begin
            cts_meta <= cts_n;
            cts_sync <= cts_meta;
            cts_prev <= cts_sync;
        end
    end

    // modem status flag, set wins over the read clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            modem_flag <= 1'b0;
        end else if (cts_sync != cts_prev) begin
            modem_flag <= 1'b1;  // see RL16
        end else if (modem_status_read) begin
            modem_flag <= 1'b0;  // see RL16
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive line status flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            line_flag <= 1'b0;
        end else if (line_status.line_error || (dma_mode && line_status.fifo_error)) begin
            line_flag <= 1'b1;  // see RL12
        end else if (line_status.lsr_read || (dma_mode && !line_status.fifo_error)) begin
            line_flag <= 1'b0;  // see RL12
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transmit request flag for non-fifo mode: set when holding empties
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_empty_prev <= 1'b0;
            tx_flag       <= 1'b0;
        end else begin
            tx_empty_prev <= tx_holding_empty;
            if (tx_holding_empty && !tx_empty_prev) begin
                tx_flag <= 1'b1;  // see RL15
            end else if (tx_holding_write) begin
                tx_flag <= 1'b0;  // see RL15
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive timeout: idle bit periods since last character or read
    assign timeout_len = 6'(TIMEOUT_MUL * (WORD_LEN_BASE + {4'h0, word_len_sel}) + TIMEOUT_ADD);
    assign timeout_hit = fifo_mode && (rx_status.level != 5'h00) && bit_tick
                         && (idle_bits == timeout_len - 6'h01);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idle_bits <= 6'h00;
        end else if (rx_status.char_in || rx_status.buf_read || rx_status.fifo_reset
                     || (rx_status.level == 5'h00)) begin
            idle_bits <= 6'h00;
        end else if (bit_tick && (idle_bits != timeout_len)) begin
            idle_bits <= idle_bits + 6'h01;  // see RL4
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timeout_flag <= 1'b0;
        end else if (timeout_hit) begin
            timeout_flag <= 1'b1;  // see RL4
        end else if (rx_status.fifo_reset || rx_status.buf_read || !fifo_mode) begin
            timeout_flag <= 1'b0;  // see RL14
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive trigger threshold
    always_comb begin
        unique case (rx_trigger_sel)
            2'h0: trigger_level = TRIG_SEL0;  // see RL18
            2'h1: trigger_level = TRIG_SEL1;
            2'h2: trigger_level = TRIG_SEL2;
            2'h3: trigger_level = TRIG_SEL3;
        endcase
    end

    // raw source conditions, one bit per source
    always_comb begin
        raw               = 5'h00;
        raw[RX_READY_BIT] = fifo_mode ? (rx_status.level >= trigger_level) : rx_status.full;  // see RL13
        raw[TX_REQ_BIT]   = fifo_mode ? (tx_level <= TX_HALF_LEVEL) : tx_flag;  // see RL15
        raw[LINE_BIT]     = line_flag;
        raw[MODEM_BIT]    = modem_flag;
        raw[TIMEOUT_BIT]  = timeout_flag;
    end

    // enable gating per source
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SOURCES; gi++) begin : g_gate
            assign pend[gi] = raw[gi] && interrupt_enable[gi];  // see RL3, see RL5, see RL6, see RL7, see RL8
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // ranking and identification value
    always_comb begin
        next_ident                  = 8'h00;
        next_ident[IDENT_PEND_BIT]  = 1'b0;
        next_ident[7:IDENT_MODE_LO] = {fifo_mode, fifo_mode};
        if (pend[LINE_BIT]) begin
            next_ident[IDENT_CODE_HI:IDENT_CODE_LO] = CODE_LINE;  // see RL12, see RL10
        end else if (pend[RX_READY_BIT]) begin
            next_ident[IDENT_CODE_HI:IDENT_CODE_LO] = CODE_RX_RDY;  // see RL13
        end else if (pend[TIMEOUT_BIT]) begin
            next_ident[IDENT_CODE_HI:IDENT_CODE_LO] = CODE_TIMEOUT;  // see RL14
        end else if (pend[TX_REQ_BIT]) begin
            next_ident[IDENT_CODE_HI:IDENT_CODE_LO] = CODE_TX_REQ;
        end else if (pend[MODEM_BIT]) begin
            next_ident[IDENT_CODE_HI:IDENT_CODE_LO] = CODE_MODEM;
        end else begin
            next_ident[IDENT_PEND_BIT] = 1'b1;  // see RL11
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            interrupt_identification <= IDENT_RESET;  // see RL9
        end else begin
            interrupt_identification <= next_ident;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // event status: rise of an enabled source, write one to clear, set wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pend_prev  <= 5'h00;
            evt_status <= EVT_STAT_RESET;
        end else begin
            pend_prev  <= pend;
            evt_status <= (evt_status & ~(stat_wr ? wdata[4:0] : 5'h00)) | (pend & ~pend_prev);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            evt_mask <= EVT_MASK_RESET;
        end else if (mask_wr) begin
            evt_mask <= wdata[4:0];
        end
    end

    // interrupt line: pending identification or unmasked event
    assign irq = !interrupt_identification[IDENT_PEND_BIT] || (|(evt_status & evt_mask));  // see RL19

    ////////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            unique case (addr)
                ENABLE_OFFSET:   rdata <= {27'h0, interrupt_enable};  // see RL1
                IDENT_OFFSET:    rdata <= {24'h0, interrupt_identification};
                EVT_STAT_OFFSET: rdata <= {27'h0, evt_status};
                EVT_MASK_OFFSET: rdata <= {27'h0, evt_mask};
                default:         rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_cts_change;
        cts_sync != cts_prev;
    endsequence

    sequence s_enable_read;
        rd && (addr == ENABLE_OFFSET);
    endsequence

    a_enable_reserved: assert property (s_enable_read |=> rdata[7:5] == 3'h0)  // see RL1
        else $error("reserved enable bits read nonzero");

    a_ident_reserved: assert property (interrupt_identification[5:4] == 2'h0)  // see RL1
        else $error("reserved ident bits nonzero");

    a_all_disabled: assert property (interrupt_enable == 5'h00 |=> interrupt_identification[IDENT_PEND_BIT])  // see RL2
        else $error("pending shown with all sources disabled");

    a_timeout_gate: assert property (!interrupt_enable[TIMEOUT_BIT]  // see RL3
                                     |=> interrupt_identification[3:1] != CODE_TIMEOUT)
        else $error("timeout reported while disabled");

    a_timeout_detect: assert property (timeout_hit |=> timeout_flag)  // see RL4
        else $error("timeout flag not set at idle limit");

    a_modem_gate: assert property (modem_flag && !interrupt_enable[MODEM_BIT]  // see RL5
                                   |=> interrupt_identification[3:0] != {CODE_MODEM, 1'b0})
        else $error("modem status reported while disabled");

    a_line_first: assert property (pend[LINE_BIT] |=> interrupt_identification[3:1] == CODE_LINE)  // see RL12
        else $error("line status not ranked first");

    a_rx_over_tx: assert property (pend[RX_READY_BIT] && !pend[LINE_BIT]  // see RL13
                                   |=> interrupt_identification[3:1] == CODE_RX_RDY)
        else $error("rx ready not ranked second");

    a_fifo_reset_clr: assert property (rx_status.fifo_reset && !timeout_hit |=> !timeout_flag)  // see RL14
        else $error("timeout not cleared by fifo reset");

    a_cts_sets: assert property (s_cts_change |=> modem_flag ##1 (modem_flag || pend[MODEM_BIT] == 1'b0))  // see RL16
        else $error("modem flag not set on cts change");

    a_irq_follows: assert property (!interrupt_identification[IDENT_PEND_BIT] |-> irq)  // see RL19
        else $error("irq low while source pending");

    a_pend_code: assert property (pend == 5'h00 |=> interrupt_identification[3:0] == 4'h1)  // see RL11
        else $error("ident not idle with nothing pending");

    // ranking below the top source, and the clear paths
    sequence s_tx_top;
        pend[TX_REQ_BIT] && !pend[LINE_BIT] && !pend[RX_READY_BIT] && !pend[TIMEOUT_BIT];
    endsequence

    a_tx_third: assert property (s_tx_top |=> interrupt_identification[3:1] == CODE_TX_REQ)  // see RL15
        else $error("tx request not ranked third");

    a_timeout_rank: assert property (pend[TIMEOUT_BIT] && !pend[LINE_BIT] && !pend[RX_READY_BIT]  // see RL14
                                     |=> interrupt_identification[3:1] == CODE_TIMEOUT)
        else $error("timeout not ranked below rx ready");

    a_modem_last: assert property (pend[MODEM_BIT] && !pend[TX_REQ_BIT] && !pend[LINE_BIT]  // see RL16
                                   && !pend[RX_READY_BIT] && !pend[TIMEOUT_BIT]
                                   |=> interrupt_identification[3:0] == {CODE_MODEM, 1'b0})
        else $error("modem status alone not reported");

    a_line_clear: assert property (line_status.lsr_read && !line_status.line_error && !dma_mode  // see RL12
                                   |=> !line_flag)
        else $error("line status not cleared by status read");

    a_trigger_top: assert property (fifo_mode && rx_trigger_sel == 2'h3 && rx_status.level >= TRIG_SEL3  // see RL18
                                    && interrupt_enable[RX_READY_BIT] && !pend[LINE_BIT]
                                    |=> interrupt_identification[3:1] == CODE_RX_RDY)
        else $error("rx ready not raised at top trigger level");

endmodule
